/* include/eia_pkg.sv */
package eia_pkg;
   localparam int          NENG        = 64;
   localparam int          NVM         = 2;
   localparam int          CLS_MISC    = 4;
   localparam int          MISC_N      = 7;
   localparam int          VF_HI       = 29;
   localparam int          VF_LO       = 27;
   localparam int          INST_HI     = 25;
   localparam int          INST_LO     = 20;
   localparam int          CLS_HI      = 18;
   localparam int          CLS_LO      = 16;
   localparam int          CLS_RENDER  = 0;
   localparam int          CLS_VDEC    = 1;
   localparam int          CLS_VENH    = 2;
   localparam int          CLS_COPY    = 3;
   localparam int          VALID_BIT   = 31;
   // Engine slots: render 0, video decode 1..8, enhance 9..12, copy 13, misc 14..20
   localparam int          BASE_VDEC   = 1;
   localparam int          BASE_VENH   = 9;
   localparam int          BASE_COPY   = 13;
   localparam int          BASE_MISC   = 14;
   localparam int          NUM_VDEC    = 8;
   localparam int          NUM_VENH    = 4;
   // Register map (byte addresses)
   localparam logic [11:0] A_CTRL      = 12'h000;
   localparam logic [11:0] A_MASTER    = 12'h004;
   localparam logic [11:0] A_WORD0     = 12'h010;
   localparam logic [11:0] A_WORD1     = 12'h014;
   localparam logic [11:0] A_SEL0      = 12'h018;
   localparam logic [11:0] A_SEL1      = 12'h01c;
   localparam logic [11:0] A_SHD0      = 12'h020;
   localparam logic [11:0] A_SHD1      = 12'h024;
   localparam logic [11:0] A_VMSEL     = 12'h028;
   localparam logic [11:0] A_CLS_EN    = 12'h040;
   localparam logic [11:0] A_MISC_EN   = 12'h060;
   localparam logic [11:0] A_MASK      = 12'h100;
   localparam logic [11:0] A_COLLAPSE  = 12'h200;
   localparam int          CTRL_SCHED  = 0;
   localparam int          MST_EN      = 31;
   localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
   localparam logic [15:0] RST_MASK    = 16'hffff;
endpackage : eia_pkg

/* design/eia_top.sv */
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module eia_top (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Engine messages
   input  wire logic        msg_valid,
   input  wire logic [31:0] msg_data,
   // Interrupt outputs
   output logic [1:0]       fw_vector_irq,
   output logic             host_irq
);

   // ***************************************************************
   // Message decode
   // ***************************************************************
   logic [2:0]  m_cls;
   logic [5:0]  m_inst;
   logic [2:0]  m_vf;
   logic [15:0] m_ev;
   logic [6:0]  m_slot;
   logic        m_ok;
   logic [3:0]  m_en_idx;
   assign m_cls  = msg_data[eia_pkg::CLS_HI:eia_pkg::CLS_LO];
   assign m_inst = msg_data[eia_pkg::INST_HI:eia_pkg::INST_LO];
   assign m_vf   = msg_data[eia_pkg::VF_HI:eia_pkg::VF_LO];
   assign m_ev   = msg_data[15:0];

   always_comb begin
      m_slot = 7'h7f;
      if (m_cls == 3'(eia_pkg::CLS_RENDER) && m_inst == 6'h00)
         m_slot = 7'h00;
      else if (m_cls == 3'(eia_pkg::CLS_VDEC) && m_inst < 6'(eia_pkg::NUM_VDEC))
         m_slot = 7'(eia_pkg::BASE_VDEC) + 7'(m_inst);
      else if (m_cls == 3'(eia_pkg::CLS_VENH) && m_inst < 6'(eia_pkg::NUM_VENH))
         m_slot = 7'(eia_pkg::BASE_VENH) + 7'(m_inst);
      else if (m_cls == 3'(eia_pkg::CLS_COPY) && m_inst == 6'h00)
         m_slot = 7'(eia_pkg::BASE_COPY);
      else if (m_cls == 3'(eia_pkg::CLS_MISC) && m_inst < 6'(eia_pkg::MISC_N))
         m_slot = 7'(eia_pkg::BASE_MISC) + 7'(m_inst);
   end
   // Enable index: classes 0..3 own 0..3, misc instances own 4..10
   assign m_en_idx = (m_cls == 3'(eia_pkg::CLS_MISC)) ? 4'(4 + m_inst) : 4'(m_cls);
   assign m_ok     = msg_valid && !m_slot[6] && (32'(m_vf) < eia_pkg::NVM);

   // ***************************************************************
   // Bus address phase capture
   // ***************************************************************
   logic        ap_wr_reg, ap_rd_reg;
   logic [11:0] ap_addr_reg;
   logic        ap_take;
   assign ap_take = hsel && hready && htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_reg   <= 1'b0;
         ap_rd_reg   <= 1'b0;
         ap_addr_reg <= 12'h000;
      end else if (hready) begin
         ap_wr_reg   <= ap_take && hwrite;
         ap_rd_reg   <= ap_take && !hwrite;
         ap_addr_reg <= haddr;
      end
   end
   logic wr_ctrl, wr_master, wr_vmsel, wr_w0, wr_w1, wr_s0, wr_s1, wr_d0, wr_d1;
   logic [1:0] wr_word, wr_sel, wr_shd;
   logic rd_w0, rd_w1;
   assign wr_ctrl   = ap_wr_reg && ap_addr_reg == eia_pkg::A_CTRL;
   assign wr_master = ap_wr_reg && ap_addr_reg == eia_pkg::A_MASTER;
   assign wr_vmsel  = ap_wr_reg && ap_addr_reg == eia_pkg::A_VMSEL;
   assign wr_w0     = ap_wr_reg && ap_addr_reg == eia_pkg::A_WORD0;
   assign wr_w1     = ap_wr_reg && ap_addr_reg == eia_pkg::A_WORD1;
   assign wr_s0     = ap_wr_reg && ap_addr_reg == eia_pkg::A_SEL0;
   assign wr_s1     = ap_wr_reg && ap_addr_reg == eia_pkg::A_SEL1;
   assign wr_d0     = ap_wr_reg && ap_addr_reg == eia_pkg::A_SHD0 && hwdata[eia_pkg::VALID_BIT];
   assign wr_d1     = ap_wr_reg && ap_addr_reg == eia_pkg::A_SHD1 && hwdata[eia_pkg::VALID_BIT];
   assign rd_w0     = ap_rd_reg && ap_addr_reg == eia_pkg::A_WORD0;
   assign rd_w1     = ap_rd_reg && ap_addr_reg == eia_pkg::A_WORD1;
   assign wr_word   = {wr_w1, wr_w0};
   assign wr_sel    = {wr_s1, wr_s0};
   assign wr_shd    = {wr_d1, wr_d0};
   logic [1:0] rd_word;
   assign rd_word   = {rd_w1, rd_w0};

   // ***************************************************************
   // Control registers
   // ***************************************************************
   logic        sched_reg;
   logic [0:0]  vmsel_reg;
   logic [15:0] cls_en_reg  [11];
   logic [15:0] mask_reg    [eia_pkg::NENG];
   logic [eia_pkg::NVM-1:0] mst_en_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sched_reg  <= 1'b0;
         vmsel_reg  <= 1'b0;
         mst_en_reg <= '0;
      end else begin
         if (wr_ctrl)
            sched_reg <= hwdata[eia_pkg::CTRL_SCHED];
         if (wr_vmsel)
            vmsel_reg <= hwdata[0];
         if (wr_master)
            mst_en_reg[vmsel_reg] <= hwdata[eia_pkg::MST_EN];
      end
   end
   genvar g;
   generate
      for (g = 0; g < 11; g++) begin : g_en
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
               cls_en_reg[g] <= 16'h0000;
            else if (ap_wr_reg && ap_addr_reg == eia_pkg::A_CLS_EN + 12'(4 * g))
               cls_en_reg[g] <= hwdata[15:0];
         end
      end
   endgenerate

   // ***************************************************************
   // Per-engine collapse stores, one set per virtual machine
   // ***************************************************************
   logic [15:0] coll_reg [eia_pkg::NVM][eia_pkg::NENG];
   logic [15:0] unmask   [eia_pkg::NVM][eia_pkg::NENG];
   logic [eia_pkg::NENG-1:0] lvl2 [eia_pkg::NVM];
   logic [31:0] sel_reg  [eia_pkg::NVM][2];
   logic [31:0] shd_reg  [eia_pkg::NVM][2];
   genvar v, e;
   generate
      for (e = 0; e < eia_pkg::NENG; e++) begin : g_mask
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
               mask_reg[e] <= eia_pkg::RST_MASK;
            else if (ap_wr_reg && ap_addr_reg == eia_pkg::A_MASK + 12'(4 * e))
               mask_reg[e] <= hwdata[15:0];
         end
      end
      for (v = 0; v < eia_pkg::NVM; v++) begin : g_vm
         for (e = 0; e < eia_pkg::NENG; e++) begin : g_eng
            logic [15:0] set_b, clr_b;
            logic        hit;
            assign hit   = m_ok && m_vf == 3'(v) && m_slot == 7'(e);
            assign set_b = hit ? (m_ev & cls_en_reg[m_en_idx]) : 16'h0000;
            // Presented bits leave the store when the selected engine is released
            assign clr_b = (wr_shd[e / 32] && vmsel_reg == 1'(v) && sel_reg[v][e / 32][e % 32])
                           ? shd_reg[v][e / 32][15:0] : 16'h0000;
            assign unmask[v][e] = coll_reg[v][e] & ~mask_reg[e];
            assign lvl2[v][e]   = |unmask[v][e];
            always_ff @(posedge hclk or negedge hresetn) begin
               if (!hresetn)
                  coll_reg[v][e] <= 16'h0000;
               else
                  coll_reg[v][e] <= (coll_reg[v][e] & ~clr_b) | set_b;
            end
         end
      end
   endgenerate

   // ***************************************************************
   // Second-level words, pending stores, selector and shared data
   // ***************************************************************
   logic [31:0] word_reg  [eia_pkg::NVM][2];
   logic [31:0] pend_reg  [eia_pkg::NVM][2];
   logic        frz_reg   [eia_pkg::NVM][2];
   logic [31:0] lvl2_prev [eia_pkg::NVM][2];
   logic [eia_pkg::NVM-1:0] wevt [2];
   genvar w;
   generate
      for (v = 0; v < eia_pkg::NVM; v++) begin : g_vw
         for (w = 0; w < 2; w++) begin : g_w
            logic [31:0] src, rise, w_left, shd_pick;
            logic        me, sel_hit;
            logic [4:0]  sel_idx;
            assign me   = vmsel_reg == 1'(v);
            assign src  = lvl2[v][32 * w +: 32];
            assign rise = src & ~lvl2_prev[v][w];
            assign w_left = (me && wr_word[w]) ? (word_reg[v][w] & ~hwdata) : word_reg[v][w];
            always_comb begin
               sel_idx = 5'h00;
               for (int i = 0; i < 32; i++)
                  if (hwdata[i])
                     sel_idx = 5'(i);
            end
            assign shd_pick = {1'b1, 15'h0000, unmask[v][32 * w + int'(sel_idx)]};
            always_ff @(posedge hclk or negedge hresetn) begin
               if (!hresetn) begin
                  word_reg[v][w]  <= eia_pkg::RST_ZERO;
                  pend_reg[v][w]  <= eia_pkg::RST_ZERO;
                  frz_reg[v][w]   <= 1'b0;
                  lvl2_prev[v][w] <= eia_pkg::RST_ZERO;
                  sel_reg[v][w]   <= eia_pkg::RST_ZERO;
                  shd_reg[v][w]   <= eia_pkg::RST_ZERO;
               end else begin
                  lvl2_prev[v][w] <= src;
                  if (w_left == 32'h0 && frz_reg[v][w]) begin
                     word_reg[v][w] <= pend_reg[v][w] | rise;
                     pend_reg[v][w] <= eia_pkg::RST_ZERO;
                     frz_reg[v][w]  <= 1'b0;
                  end else if (frz_reg[v][w] || (me && rd_word[w])) begin
                     word_reg[v][w] <= w_left;
                     pend_reg[v][w] <= pend_reg[v][w] | rise;
                     frz_reg[v][w]  <= 1'b1;
                  end else
                     word_reg[v][w] <= w_left | rise;
                  if (me && wr_shd[w]) begin
                     sel_reg[v][w] <= eia_pkg::RST_ZERO;
                     shd_reg[v][w] <= eia_pkg::RST_ZERO;
                  end else if (me && wr_sel[w]) begin
                     sel_reg[v][w] <= hwdata;
                     shd_reg[v][w] <= (hwdata == 32'h0) ? eia_pkg::RST_ZERO : shd_pick;
                  end
               end
            end
            assign wevt[w][v] = |word_reg[v][w];
         end
      end
   endgenerate

   // ***************************************************************
   // Interrupt routing
   // ***************************************************************
   logic [1:0] fw_next;
   logic       host_next;
   always_comb begin
      fw_next   = 2'b00;
      host_next = 1'b0;
      for (int i = 0; i < eia_pkg::NVM; i++) begin
         if (sched_reg)
            fw_next = fw_next | {wevt[1][i], wevt[0][i]};
         else if (mst_en_reg[i] && (wevt[0][i] || wevt[1][i]))
            host_next = 1'b1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fw_vector_irq <= 2'b00;
         host_irq      <= 1'b0;
      end else begin
         fw_vector_irq <= fw_next;
         host_irq      <= host_next;
      end
   end

   // ***************************************************************
   // Read data
   // ***************************************************************
   logic [31:0] rd_mux;
   logic [11:0] ra;
   assign ra = ap_addr_reg;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (ra == eia_pkg::A_CTRL)
         rd_mux = {31'h0, sched_reg};
      else if (ra == eia_pkg::A_MASTER)
         rd_mux = {mst_en_reg[vmsel_reg], 29'h0,
                   !sched_reg && wevt[1][vmsel_reg], !sched_reg && wevt[0][vmsel_reg]};
      else if (ra == eia_pkg::A_WORD0)
         rd_mux = word_reg[vmsel_reg][0];
      else if (ra == eia_pkg::A_WORD1)
         rd_mux = word_reg[vmsel_reg][1];
      else if (ra == eia_pkg::A_SEL0)
         rd_mux = sel_reg[vmsel_reg][0];
      else if (ra == eia_pkg::A_SEL1)
         rd_mux = sel_reg[vmsel_reg][1];
      else if (ra == eia_pkg::A_SHD0)
         rd_mux = shd_reg[vmsel_reg][0];
      else if (ra == eia_pkg::A_SHD1)
         rd_mux = shd_reg[vmsel_reg][1];
      else if (ra == eia_pkg::A_VMSEL)
         rd_mux = {31'h0, vmsel_reg};
      else if (ra >= eia_pkg::A_CLS_EN && ra < eia_pkg::A_CLS_EN + 12'h02c)
         rd_mux = {16'h0, cls_en_reg[4'((ra - eia_pkg::A_CLS_EN) >> 2)]};
      else if (ra >= eia_pkg::A_MASK && ra < eia_pkg::A_MASK + 12'h100)
         rd_mux = {16'h0, mask_reg[6'((ra - eia_pkg::A_MASK) >> 2)]};
      else if (ra >= eia_pkg::A_COLLAPSE && ra < eia_pkg::A_COLLAPSE + 12'h100)
         rd_mux = {16'h0, coll_reg[vmsel_reg][6'((ra - eia_pkg::A_COLLAPSE) >> 2)]};
   end
   assign hrdata    = ap_rd_reg ? rd_mux : 32'h0;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_host_irq;
      @(posedge hclk) disable iff (!hresetn)
      (!sched_reg && mst_en_reg[0] && wevt[0][0]) |=> host_irq;
   endproperty
   a_host_irq: assert property (p_host_irq) else $error("host irq missing");
   property p_sched_quiet;
      @(posedge hclk) disable iff (!hresetn)
      $past(sched_reg) |-> !host_irq;
   endproperty
   a_sched_quiet: assert property (p_sched_quiet) else $error("host irq in sched mode");
   property p_fw_vec;
      @(posedge hclk) disable iff (!hresetn)
      (sched_reg && wevt[1][0]) |=> fw_vector_irq[1];
   endproperty
   a_fw_vec: assert property (p_fw_vec) else $error("fw vector missing");
   property p_freeze;
      @(posedge hclk) disable iff (!hresetn)
      (frz_reg[0][0] && word_reg[0][0] != 32'h0 && !(vmsel_reg == 1'b0 && wr_w0))
      |=> word_reg[0][0] == $past(word_reg[0][0]);
   endproperty
   a_freeze: assert property (p_freeze) else $error("frozen word changed");
   property p_sel_valid;
      @(posedge hclk) disable iff (!hresetn)
      (vmsel_reg == 1'b0 && wr_s0 && hwdata != 32'h0 && !wr_d0) |=> shd_reg[0][0][eia_pkg::VALID_BIT];
   endproperty
   a_sel_valid: assert property (p_sel_valid) else $error("valid not set");
   property p_shd_clr;
      @(posedge hclk) disable iff (!hresetn)
      (vmsel_reg == 1'b0 && wr_d0) |=> sel_reg[0][0] == 32'h0 && shd_reg[0][0] == 32'h0;
   endproperty
   a_shd_clr: assert property (p_shd_clr) else $error("shared clear failed");
   property p_disabled_drop;
      @(posedge hclk) disable iff (!hresetn)
      (m_ok && m_vf == 3'h0 && m_slot == 7'h00 && cls_en_reg[0] == 16'h0
       && coll_reg[0][0] == 16'h0) |=> coll_reg[0][0] == 16'h0;
   endproperty
   a_disabled_drop: assert property (p_disabled_drop) else $error("disabled event kept");
   property p_masked_hold;
      @(posedge hclk) disable iff (!hresetn)
      (coll_reg[0][0] != 16'h0 && !lvl2[0][0] && !wr_d0) |=> coll_reg[0][0] != 16'h0;
   endproperty
   a_masked_hold: assert property (p_masked_hold) else $error("masked event lost");
   property p_store_release;
      @(posedge hclk) disable iff (!hresetn)
      (vmsel_reg == 1'b0 && wr_d0 && sel_reg[0][0][0] && !(m_ok && m_vf == 3'h0 && m_slot == 7'h00))
      |=> (coll_reg[0][0] & $past(shd_reg[0][0][15:0])) == 16'h0;
   endproperty
   a_store_release: assert property (p_store_release) else $error("presented bits kept");
endmodule : eia_top

/* dv/eia_engine_model.sv */
`timescale 1ns/10ps
module eia_engine_model (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Request from the bench
   input  wire logic        send,
   input  wire logic [2:0]  cls,
   input  wire logic [5:0]  inst,
   input  wire logic [2:0]  vf,
   input  wire logic [15:0] evt,
   // Message to the aggregator
   output logic             msg_valid,
   output logic [31:0]      msg_data
);
   // One-cycle message; between messages the data lines toggle so nothing stale is mistaken for data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         msg_valid <= 1'b0;
         msg_data  <= 32'h0000_0000;
      end else if (send) begin
         msg_valid <= 1'b1;
         msg_data  <= {2'b00, vf, 1'b0, inst, 1'b0, cls, evt};
      end else begin
         msg_valid <= 1'b0;
         msg_data  <= ~msg_data;
      end
   end
endmodule : eia_engine_model

/* dv/engine_interrupt_aggregator_tb.sv */
`timescale 1ns/10ps
module engine_interrupt_aggregator_tb;
   logic        hclk, hresetn, hsel, hwrite, send, hreadyout, hresp, msg_valid, host_irq;
   logic [11:0] haddr;
   logic [1:0]  htrans, fw_vector_irq;
   logic [2:0]  hsize, cls, vf;
   logic [31:0] hwdata, hrdata, msg_data, seed, rd;
   logic [5:0]  inst;
   logic [15:0] evt;
   logic [15:0] ev [0:15];
   int          errors, n_compared, cycles;

   eia_top eia_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .msg_valid(msg_valid), .msg_data(msg_data),
      .fw_vector_irq(fw_vector_irq), .host_irq(host_irq));
   eia_engine_model eia_engine_model_inst (.hclk(hclk), .hresetn(hresetn), .send(send), .cls(cls),
      .inst(inst), .vf(vf), .evt(evt), .msg_valid(msg_valid), .msg_data(msg_data));

   always #50 hclk = ~hclk;

   // ******************
   // Helpers
   // ******************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [31:0] shd_exp(input logic [15:0] e);
      return {1'b1, 15'h0000, e};
   endfunction : shd_exp

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask : rc

   task automatic msg(input logic [2:0] c, input logic [5:0] i, input logic [15:0] e);
      send <= 1'b1;
      cls  <= c;
      inst <= i;
      evt  <= e;
      @(posedge hclk);
      send <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask : msg

   task automatic service(input int s, input logic [15:0] e);
      wr(eia_pkg::A_SEL0, 32'h1 << s);
      rc(eia_pkg::A_SHD0, shd_exp(e));
      wr(eia_pkg::A_SHD0, 32'h8000_0000);
      rc(eia_pkg::A_SHD0, 32'h0000_0000);
      rc(eia_pkg::A_SEL0, 32'h0000_0000);
      rc(eia_pkg::A_COLLAPSE + 12'(4 * s), 32'h0000_0000);
   endtask : service

   task automatic test_done;
      $display("TB counts: compared=%0d errors=%0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done

   always @(posedge hclk) begin
      cycles++;
      if (cycles >= 4000) begin
         errors++;
         test_done();
      end
   end

   // ******************
   // Main sequence
   // ******************
   initial begin
      {hclk, hresetn, hsel, hwrite, send} = 5'b00000;
      {haddr, htrans, hsize, hwdata, cls, vf, inst, evt} = '0;
      hsize = 3'b010;
      errors = 0;
      n_compared = 0;
      cycles = 0;
      seed = 32'h0000_cf44;
      for (int k = 0; k < 16; k++) begin
         seed = lfsr(seed);
         ev[k] = seed[15:0] | 16'h0001;
      end
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rc(eia_pkg::A_WORD0, 32'h0000_0000);
      rc(eia_pkg::A_SHD0, 32'h0000_0000);
      rc(eia_pkg::A_MASK, 32'h0000_ffff);
      rc(12'h030, 32'h0000_0000);
      $display("test reset done");
      msg(3'd0, 6'd0, ev[0]);
      rc(eia_pkg::A_COLLAPSE, 32'h0000_0000);
      wr(eia_pkg::A_CLS_EN, 32'h0000_ffff);
      msg(3'd0, 6'd0, ev[0]);
      rc(eia_pkg::A_COLLAPSE, {16'h0000, ev[0]});
      rc(eia_pkg::A_MASTER, 32'h0000_0000);
      wr(eia_pkg::A_MASK, 32'h0000_0000);
      rc(eia_pkg::A_MASTER, 32'h0000_0001);
      wr(eia_pkg::A_MASTER, 32'h8000_0000);
      repeat (3) @(posedge hclk);
      chk({31'h0, host_irq}, 32'h1);
      wr(eia_pkg::A_MASTER, 32'h0000_0000);
      rc(eia_pkg::A_MASTER, 32'h0000_0001);
      chk({31'h0, host_irq}, 32'h0);
      rc(eia_pkg::A_WORD0, 32'h0000_0001);
      service(0, ev[0]);
      wr(eia_pkg::A_WORD0, 32'h0000_0001);
      wr(eia_pkg::A_MASTER, 32'h8000_0000);
      rc(eia_pkg::A_MASTER, 32'h8000_0000);
      chk({31'h0, host_irq}, 32'h0);
      $display("test host path done");
      wr(eia_pkg::A_CLS_EN + 12'h004, 32'h0000_ffff);
      wr(eia_pkg::A_CLS_EN + 12'h00c, 32'h0000_ffff);
      foreach (ev[k]) if (k == 1 || k == 2 || k == 13) wr(eia_pkg::A_MASK + 12'(4 * k), 32'h0);
      msg(3'd1, 6'd0, ev[1]);
      msg(3'd1, 6'd1, ev[2]);
      rc(eia_pkg::A_WORD0, 32'h0000_0006);
      msg(3'd3, 6'd0, ev[13]);
      rc(eia_pkg::A_WORD0, 32'h0000_0006);
      service(1, ev[1]);
      service(2, ev[2]);
      wr(eia_pkg::A_WORD0, 32'h0000_0006);
      rc(eia_pkg::A_WORD0, 32'h0000_2000);
      $display("test freeze done");
      wr(eia_pkg::A_CTRL, 32'h0000_0001);
      repeat (3) @(posedge hclk);
      chk({30'h0, fw_vector_irq}, 32'h1);
      chk({31'h0, host_irq}, 32'h0);
      service(13, ev[13]);
      wr(eia_pkg::A_WORD0, 32'h0000_2000);
      repeat (3) @(posedge hclk);
      chk({30'h0, fw_vector_irq}, 32'h0);
      $display("test scheduler done");
      wr(eia_pkg::A_CLS_EN + 12'h010, 32'h0000_ffff);
      wr(eia_pkg::A_MASK + 12'h038, 32'h0000_0000);
      wr(eia_pkg::A_MASK + 12'h03c, 32'h0000_0000);
      msg(3'd4, 6'd0, ev[4]);
      msg(3'd4, 6'd1, ev[5]);
      rc(eia_pkg::A_COLLAPSE + 12'h03c, 32'h0000_0000);
      rc(eia_pkg::A_WORD0, 32'h0000_4000);
      service(14, ev[4]);
      wr(eia_pkg::A_WORD0, 32'h0000_4000);
      $display("test misc enable done");
      vf <= 3'd1;
      msg(3'd0, 6'd0, ev[6]);
      vf <= 3'd2;
      msg(3'd0, 6'd0, ev[7]);
      vf <= 3'd0;
      rc(eia_pkg::A_COLLAPSE, 32'h0000_0000);
      wr(eia_pkg::A_VMSEL, 32'h0000_0001);
      rc(eia_pkg::A_COLLAPSE, {16'h0000, ev[6]});
      rc(eia_pkg::A_WORD0, 32'h0000_0001);
      chk({30'h0, fw_vector_irq}, 32'h1);
      service(0, ev[6]);
      wr(eia_pkg::A_WORD0, 32'h0000_0001);
      rc(eia_pkg::A_WORD0, 32'h0000_0000);
      wr(eia_pkg::A_VMSEL, 32'h0000_0000);
      $display("test vm copies done");
      test_done();
   end
endmodule : engine_interrupt_aggregator_tb
